// >>> src/iod_decode.sv
// I/O space access decoder and register bank for the execution unit
`timescale 1ns/100ps
module iod_decode
    import iod_pkg::*;
#(
    parameter int IO_LOCS = IOD_IO_LOCS, // I/O register count
    parameter int EXT_LOCS = IOD_EXT_LOCS // Extended register count
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Request from the execution unit
    input wire iod_pkg::iod_req_t req,
    // Answer to the execution unit
    output iod_pkg::iod_rsp_t rsp,
    // Flag configuration and events, one byte per I/O address
    input wire logic [IO_LOCS*8-1:0] w1c_mask,
    input wire logic [IO_LOCS*8-1:0] hw_set,
    // Register contents towards the peripherals
    output logic [IO_LOCS*8-1:0] io_regs,
    output logic [EXT_LOCS*8-1:0] ext_regs
);
    import iod_pkg::*;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // True when the address lies in [lo, hi]
    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // One-hot mask of a bit position
    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = 8'h01 << b;
    endfunction

    // ************************************************************
    // Address decode
    // ************************************************************
    logic is_io_op; // I/O-specific read or write
    logic is_bit_op; // Set or clear a single bit
    logic is_data_op; // Load or store in data space
    logic io_hit; // Access lands in I/O registers
    logic ext_hit; // Access lands in extended registers
    logic [7:0] io_idx; // I/O index of the target
    logic [7:0] ext_idx; // Extended index of the target
    logic wr_io; // Write to an I/O register
    logic [7:0] wr_bits; // Bits written by this access

    always_comb begin
        is_io_op = (req.op == IOD_OP_IO_READ) ||
                   (req.op == IOD_OP_IO_WRITE);
        is_bit_op = (req.op == IOD_OP_SET_BIT) ||
                    (req.op == IOD_OP_CLR_BIT);
        is_data_op = (req.op == IOD_OP_DATA_READ) ||
                     (req.op == IOD_OP_DATA_WRITE);
        io_idx = req.addr;
        ext_idx = req.addr - IOD_EXT_FIRST;
        io_hit = 1'b0;
        ext_hit = 1'b0;
        if (is_io_op) begin
            // Opcode field covers only the low 64 locations
            io_hit = in_range(req.addr, 8'h00, IOD_IO_LAST);
        end else if (is_bit_op) begin
            // High I/O addresses ignore bit operations
            io_hit = in_range(req.addr, 8'h00, IOD_BIT_IO_LAST);
        end else if (is_data_op) begin
            // Data space sees the I/O block shifted up
            io_idx = req.addr - IOD_DATA_OFFSET;
            io_hit = in_range(req.addr, IOD_DATA_OFFSET,
                              IOD_EXT_FIRST - 8'h01);
            ext_hit = in_range(req.addr, IOD_EXT_FIRST,
                               IOD_EXT_LAST);
        end
        wr_io = io_hit && (req.op == IOD_OP_IO_WRITE ||
                           req.op == IOD_OP_DATA_WRITE || is_bit_op);
        // Bit ops write only their own bit, so other flags survive
        wr_bits = is_bit_op ? bit_mask(req.bit_sel) : 8'hff;
    end

    // ************************************************************
    // Write data forming
    // ************************************************************
    logic [7:0] cell_wdata; // Data presented to the target byte

    // Set/clear build the new bit; flags see a one only on set
    always_comb begin
        case (req.op)
            IOD_OP_SET_BIT: cell_wdata = 8'hff;
            IOD_OP_CLR_BIT: cell_wdata = 8'h00;
            default: cell_wdata = req.wdata;
        endcase
    end

    // ************************************************************
    // I/O register bank
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < IO_LOCS; g++) begin : g_io
            iod_flag_cell u_cell (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .w1c_mask(w1c_mask[g*8 +: 8]),
                .wr_en(wr_io && (io_idx == 8'(g))),
                .wr_bits(wr_bits),
                .wdata(cell_wdata),
                .hw_set(hw_set[g*8 +: 8]),
                .value(io_regs[g*8 +: 8])
            );
        end
    endgenerate

    // ************************************************************
    // Extended register memory
    // ************************************************************
    logic [7:0] ext_mem [EXT_LOCS]; // Plain read/write storage

    // Stores only; I/O instructions never reach here
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            for (int i = 0; i < EXT_LOCS; i++) ext_mem[i] <= IOD_RESET_VAL;
        end else if (ext_hit && req.op == IOD_OP_DATA_WRITE) begin
            ext_mem[ext_idx] <= req.wdata;
        end
    end

    always_comb begin
        for (int i = 0; i < EXT_LOCS; i++) ext_regs[i*8 +: 8] = ext_mem[i];
    end

    // ************************************************************
    // Answer
    // ************************************************************
    logic [7:0] rd_byte; // Byte at the decoded target

    always_comb begin
        rd_byte = 8'h00;
        if (io_hit) rd_byte = io_regs[io_idx[5:0]*8 +: 8];
        else if (ext_hit) rd_byte = ext_mem[ext_idx];
    end

    // Registered answer, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rsp <= '0;
        end else begin
            rsp.valid <= (req.op != IOD_OP_NONE);
            rsp.hit <= io_hit || ext_hit;
            rsp.rdata <= rd_byte;
            // Skip tests use the low range only
            rsp.bit_val <= (is_io_op &&
                            in_range(req.addr, 8'h00, IOD_BIT_IO_LAST))
                           ? rd_byte[req.bit_sel] : 1'b0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_bit_high_noop;
        @(posedge ref_clk) disable iff (!rstn)
        (req.op == IOD_OP_SET_BIT && req.addr > IOD_BIT_IO_LAST)
        |=> !rsp.hit;
    endproperty
    a_bit_high_noop: assert property (p_bit_high_noop)
        else $error("bit op hit high I/O");

    property p_io_ext_miss;
        @(posedge ref_clk) disable iff (!rstn)
        (is_io_op && req.addr > IOD_IO_LAST) |=> !rsp.hit;
    endproperty
    a_io_ext_miss: assert property (p_io_ext_miss)
        else $error("I/O op reached extended space");

    sequence s_set_low;
        req.op == IOD_OP_SET_BIT && req.addr <= IOD_BIT_IO_LAST;
    endsequence
    // Old byte and flag events are captured when the request is taken
    property p_set_one_bit;
        logic [7:0] a;
        logic [2:0] b;
        logic [7:0] old;
        logic [7:0] hw;
        @(posedge ref_clk) disable iff (!rstn)
        (s_set_low, a = req.addr, b = req.bit_sel,
         old = io_regs[req.addr[5:0]*8 +: 8],
         hw = hw_set[req.addr[5:0]*8 +: 8]) |=>
        (((io_regs[a[5:0]*8 +: 8] ^ old) & ~bit_mask(b) & ~hw) == 8'h00);
    endproperty
    a_set_one_bit: assert property (p_set_one_bit)
        else $error("bit op changed other bits");

    property p_data_offset;
        @(posedge ref_clk) disable iff (!rstn)
        (req.op == IOD_OP_DATA_READ &&
         in_range(req.addr, IOD_DATA_OFFSET, IOD_EXT_FIRST - 8'h01))
        |=> rsp.hit && rsp.rdata ==
            $past(io_regs[6'(req.addr - IOD_DATA_OFFSET)*8 +: 8]);
    endproperty
    a_data_offset: assert property (p_data_offset)
        else $error("data offset read wrong");

    property p_answer_valid;
        @(posedge ref_clk) disable iff (!rstn)
        (req.op == IOD_OP_IO_READ && req.addr <= IOD_IO_LAST)
        |=> rsp.valid && rsp.hit;
    endproperty
    a_answer_valid: assert property (p_answer_valid)
        else $error("I/O read not answered");

    // High I/O reads are not skip targets, so no bit is reported
    sequence s_skip_high;
        req.op == IOD_OP_IO_READ && req.addr > IOD_BIT_IO_LAST;
    endsequence
    property p_skip_high;
        @(posedge ref_clk) disable iff (!rstn)
        s_skip_high |=> !rsp.bit_val;
    endproperty
    a_skip_high: assert property (p_skip_high)
        else $error("skip test read high I/O bit");

endmodule

// >>> include/iod_pkg.sv
// Package: constants and carrier types for the I/O space decoder
package iod_pkg;

    // ************************************************************
    // Address map
    // ************************************************************
    localparam logic [7:0] IOD_BIT_IO_LAST = 8'h1f; // Last bit-reachable
    localparam logic [7:0] IOD_IO_LAST = 8'h3f; // Last I/O-instr address
    localparam logic [7:0] IOD_DATA_OFFSET = 8'h20; // Data-space offset
    localparam logic [7:0] IOD_EXT_FIRST = 8'h60; // First extended addr
    localparam logic [7:0] IOD_EXT_LAST = 8'hff; // Last extended addr
    localparam int IOD_IO_LOCS = 64; // I/O opcode field locations
    localparam int IOD_EXT_LOCS = 160; // Extended locations
    localparam logic [7:0] IOD_RESET_VAL = 8'h00; // Register reset value

    // ************************************************************
    // Access kinds
    // ************************************************************
    typedef enum logic [6:0] {
        IOD_OP_NONE = 7'h01, // Idle
        IOD_OP_IO_READ = 7'h02, // I/O-specific read
        IOD_OP_IO_WRITE = 7'h04, // I/O-specific write
        IOD_OP_SET_BIT = 7'h08, // set_io_bit_instr
        IOD_OP_CLR_BIT = 7'h10, // clear_io_bit_instr
        IOD_OP_DATA_READ = 7'h20, // Any data-space load variant
        IOD_OP_DATA_WRITE = 7'h40 // Any data-space store variant
    } iod_op_t;

    // Request from the execution unit
    typedef struct packed {
        iod_op_t op; // Access kind
        logic [7:0] addr; // I/O or data address per op
        logic [2:0] bit_sel; // Bit for bit ops and skip tests
        logic [7:0] wdata; // Write data
    } iod_req_t;

    // Answer to the execution unit
    typedef struct packed {
        logic valid; // Answer present this cycle
        logic hit; // Address mapped for this op
        logic [7:0] rdata; // Read data
        logic bit_val; // Selected bit value for skip tests
    } iod_rsp_t;

endpackage

// >>> src/iod_flag_cell.sv
// One I/O register byte with per-bit write-one-to-clear flags
`timescale 1ns/100ps
module iod_flag_cell
    import iod_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Configuration: which bits are clear-on-one flags
    input wire logic [7:0] w1c_mask,
    // Write side
    input wire logic wr_en,
    input wire logic [7:0] wr_bits, // Bits affected by this write
    input wire logic [7:0] wdata,
    // Hardware flag events
    input wire logic [7:0] hw_set,
    // Stored value
    output logic [7:0] value
);
    import iod_pkg::*;

    // ************************************************************
    // Storage
    // ************************************************************
    // Plain bits store data; flag bits clear on a written one. A
    // hardware set in the same cycle wins over the clear.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            value <= IOD_RESET_VAL;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (w1c_mask[i] && hw_set[i]) begin
                    value[i] <= 1'b1;
                end else if (wr_en && wr_bits[i]) begin
                    if (w1c_mask[i]) begin
                        // Only a one clears; zero leaves it alone
                        if (wdata[i]) value[i] <= 1'b0;
                    end else begin
                        value[i] <= wdata[i];
                    end
                end
            end
        end
    end

endmodule

// >>> verif/iod_exec_model.sv
// Execution-unit stand-in issuing one request per call
`timescale 1ns/100ps
module iod_exec_model
    import iod_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Request towards the decoder
    output iod_pkg::iod_req_t req,
    // Answer from the decoder
    input wire iod_pkg::iod_rsp_t rsp
);
    // Answer to the request of the previous call
    iod_rsp_t got;
    // Idle until the first call
    initial begin
        req = '{IOD_OP_NONE, 8'h00, 3'h0, 8'h00};
    end
    // Falling edge: collect last answer, then drive the next request
    // Calls back to back give one request every cycle
    task automatic issue(input iod_req_t r);
        @(negedge ref_clk);
        got = rsp;
        req = r;
    endtask
endmodule

// >>> verif/iod_decode_bench.sv
// Self-checking bench for the I/O space decoder
`timescale 1ns/100ps
module iod_decode_bench;
    import iod_pkg::*;
    // ****************************************
    // Table and signals
    // ****************************************
    // Row: request, check depth (0..3), expected hit, data, bit
    typedef struct {
        iod_op_t op;
        logic [7:0] a;
        logic [2:0] b;
        logic [7:0] d;
        int c;
        logic h;
        logic [7:0] q;
        logic v;
    } iod_row_t;
    localparam int FLAG_LSB = 32'h1c * 8; // Flag byte position
    localparam iod_req_t IDLE = '{IOD_OP_NONE, 8'h00, 3'h0, 8'h00};
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    iod_req_t req;
    iod_rsp_t rsp;
    iod_rsp_t g;
    iod_row_t r;
    logic [IOD_IO_LOCS*8-1:0] w1c_mask = '0;
    logic [IOD_IO_LOCS*8-1:0] hw_set = '0;
    logic [IOD_IO_LOCS*8-1:0] io_regs;
    logic [IOD_EXT_LOCS*8-1:0] ext_regs;
    int err_count = 0;
    int compares = 0;
    // Boundaries of each range; back-to-back read after write
    iod_row_t rows[20] = '{
        '{IOD_OP_IO_WRITE, 8'h05, 3'h0, 8'haa, 1, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_IO_READ, 8'h05, 3'h1, 8'h00, 3, 1'b1, 8'haa, 1'b1},
        '{IOD_OP_DATA_READ, 8'h25, 3'h0, 8'h00, 2, 1'b1, 8'haa, 1'b0},
        '{IOD_OP_SET_BIT, 8'h05, 3'h0, 8'h00, 0, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_CLR_BIT, 8'h05, 3'h7, 8'h00, 0, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_IO_READ, 8'h05, 3'h7, 8'h00, 3, 1'b1, 8'h2b, 1'b0},
        '{IOD_OP_SET_BIT, 8'h20, 3'h0, 8'h00, 0, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_IO_READ, 8'h20, 3'h0, 8'h00, 3, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_DATA_WRITE, 8'h5f, 3'h0, 8'h33, 1, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_IO_READ, 8'h3f, 3'h0, 8'h00, 2, 1'b1, 8'h33, 1'b0},
        '{IOD_OP_IO_READ, 8'h40, 3'h0, 8'h00, 2, 1'b0, 8'h00, 1'b0},
        '{IOD_OP_DATA_WRITE, 8'h60, 3'h0, 8'h77, 1, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_DATA_READ, 8'h60, 3'h0, 8'h00, 2, 1'b1, 8'h77, 1'b0},
        '{IOD_OP_DATA_WRITE, 8'hff, 3'h0, 8'h5c, 1, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_DATA_READ, 8'hff, 3'h0, 8'h00, 2, 1'b1, 8'h5c, 1'b0},
        '{IOD_OP_DATA_READ, 8'h1f, 3'h0, 8'h00, 2, 1'b0, 8'h00, 1'b0},
        '{IOD_OP_IO_WRITE, 8'h50, 3'h0, 8'h11, 1, 1'b0, 8'h00, 1'b0},
        '{IOD_OP_DATA_READ, 8'h70, 3'h0, 8'h00, 2, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_SET_BIT, 8'h1f, 3'h6, 8'h00, 0, 1'b1, 8'h00, 1'b0},
        '{IOD_OP_IO_READ, 8'h1f, 3'h6, 8'h00, 3, 1'b1, 8'h40, 1'b1}
    };
    // ****************************************
    // Instances, clock, watchdog
    // ****************************************
    iod_decode #(.IO_LOCS(IOD_IO_LOCS), .EXT_LOCS(IOD_EXT_LOCS))
    u_iod_decode (.ref_clk(ref_clk), .rstn(rstn), .req(req), .rsp(rsp),
        .w1c_mask(w1c_mask), .hw_set(hw_set), .io_regs(io_regs),
        .ext_regs(ext_regs));
    iod_exec_model u_iod_exec_model (.ref_clk(ref_clk), .req(req),
        .rsp(rsp));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Run needs about 54 cycles; far more means a hang
    initial begin
        repeat (1000) @(posedge ref_clk);
        err_count++;
        final_report();
    end
    // ****************************************
    // Tasks
    // ****************************************
    task cmp(input logic [10:0] e, input logic [10:0] x);
        compares++;
        if (x !== e) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, x);
        end
    endtask
    // Access the flag byte, then compare its stored value
    task fl(input iod_op_t op, input logic [2:0] b,
            input logic [7:0] d, input logic [7:0] e);
        u_iod_exec_model.issue(iod_req_t'{op, 8'h1c, b, d});
        u_iod_exec_model.issue(IDLE);
        cmp({3'h0, e}, {3'h0, io_regs[FLAG_LSB +: 8]});
    endtask
    task final_report();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        w1c_mask[FLAG_LSB +: 8] = 8'h03; // Two flags in byte 0x1c
        repeat (16) @(negedge ref_clk);
        rstn = 1'b1;
        cmp(11'h000, {10'h000, |{io_regs, ext_regs, rsp}});
        $display("reset test done");
        // Pipelined: answer of row i-1 arrives while row i goes out
        for (int i = 0; i <= 20; i++) begin
            u_iod_exec_model.issue(i < 20 ? iod_req_t'{rows[i].op,
                rows[i].a, rows[i].b, rows[i].d} : IDLE);
            if (i > 0) begin
                r = rows[i-1];
                g = u_iod_exec_model.got;
                cmp({1'b1, r.h, r.q, r.v}, {g.valid, r.c > 0 ? g.hit : r.h,
                    r.c > 1 ? g.rdata : r.q,
                    r.c > 2 ? g.bit_val : r.v});
            end
        end
        cmp({3'h0, 8'h77}, {3'h0, ext_regs[7:0]});
        cmp({3'h0, 8'h5c},
            {3'h0, ext_regs[(IOD_EXT_LOCS-1)*8 +: 8]});
        $display("table test done");
        // Hardware raises both flags, then software clears them
        @(negedge ref_clk);
        hw_set[FLAG_LSB +: 8] = 8'h03;
        @(negedge ref_clk);
        hw_set = '0;
        cmp(11'h003, {3'h0, io_regs[FLAG_LSB +: 8]});
        fl(IOD_OP_CLR_BIT, 3'h1, 8'h00, 8'h03);
        fl(IOD_OP_SET_BIT, 3'h0, 8'h00, 8'h02);
        fl(IOD_OP_IO_WRITE, 3'h0, 8'h00, 8'h02);
        fl(IOD_OP_IO_WRITE, 3'h0, 8'h02, 8'h00);
        // Flag event and clearing write in one cycle: the event wins
        u_iod_exec_model.issue(iod_req_t'{IOD_OP_IO_WRITE, 8'h1c, 3'h0,
            8'h01});
        hw_set[FLAG_LSB +: 8] = 8'h01;
        u_iod_exec_model.issue(IDLE);
        hw_set = '0;
        cmp(11'h001, {3'h0, io_regs[FLAG_LSB +: 8]});
        $display("flag test done");
        // Second reset in mid-run wipes written registers
        @(negedge ref_clk);
        rstn = 1'b0;
        @(negedge ref_clk);
        cmp(11'h000, {10'h000, |{io_regs, ext_regs, rsp}});
        rstn = 1'b1;
        // First read after the mid-run reset sees the wiped byte
        u_iod_exec_model.issue(iod_req_t'{IOD_OP_IO_READ, 8'h05, 3'h1,
            8'h00});
        u_iod_exec_model.issue(IDLE);
        g = u_iod_exec_model.got;
        cmp({1'b1, 1'b1, 8'h00, 1'b0}, g);
        // An idle cycle gives no answer at all
        u_iod_exec_model.issue(IDLE);
        g = u_iod_exec_model.got;
        cmp(11'h000, g);
        $display("second reset test done");
        final_report();
    end
endmodule
